/* src/pixel_bus_mode_unpacker.sv */
// Our own choices: the strobed register port and the address map.
`timescale 1ns/1ps
module pixel_bus_mode_unpacker
   import pixel_unpack_pkg::*;
#(
   parameter int PIX_W = 32
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // register port
   input  wire logic [3:0]  regAddr,
   input  wire logic [7:0]  regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [7:0]  regRdData,
   // pins from the video memory side
   input  wire logic        shiftClock,
   input  wire logic        perDotClock,
   input  wire logic        nibbleHalfFlag,
   input  wire logic [31:0] pixelBus,
   input  wire logic [7:0]  legacyPort,
   // per-dot output
   output logic             pixValid,
   output logic      [7:0]  paletteAddr,
   output logic             directColour,
   output logic      [7:0]  red,
   output logic      [7:0]  green,
   output logic      [7:0]  blue,
   output logic      [7:0]  overlay
);

   if (PIX_W != 32) begin : g_width_check
      $error("pixel bus width must be 32");
   end

   // pin synchronisation; bus is stable across the shift edge, which is delayed equally
   logic [42:0] pinSync;
   logic        shiftSync;
   logic        dotSync;
   logic        flagSync;
   logic [7:0]  legacySync;
   logic [31:0] pixSync;

   sync_2ff #(
      .W (43)
   ) u_pin_sync (
      .sys_clk (sys_clk),
      .rst     (rst),
      .asyncIn ({shiftClock, perDotClock, nibbleHalfFlag, legacyPort, pixelBus}),
      .syncOut (pinSync)
   );

   assign shiftSync  = pinSync[42];
   assign dotSync    = pinSync[41];
   assign flagSync   = pinSync[40];
   assign legacySync = pinSync[39:32];
   assign pixSync    = pinSync[31:0];

   logic shiftPrev_ff;
   logic dotPrev_ff;
   logic shiftRise;
   logic dotRise;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         shiftPrev_ff <= 1'b0;
         dotPrev_ff   <= 1'b0;
      end else begin
         shiftPrev_ff <= shiftSync;
         dotPrev_ff   <= dotSync;
      end
   end

   assign shiftRise = shiftSync & ~shiftPrev_ff;
   assign dotRise   = dotSync & ~dotPrev_ff;

   // register file
   logic [7:0] muxSel_ff;
   logic [7:0] genCtrl_ff;
   logic [7:0] palPage_ff;
   logic [7:0] rdData_ff;
   logic [7:0] nxt_muxSel_ff;
   logic [7:0] nxt_genCtrl_ff;
   logic [7:0] nxt_palPage_ff;
   logic [7:0] nxt_rdData_ff;
   logic       flush;

   mode_t      mode_ff;
   logic [5:0] groupsLeft_ff;

   assign flush = regWr && (regAddr == REG_MUX_SEL || regAddr == REG_GEN_CTRL);

   always_comb begin
      nxt_muxSel_ff  = muxSel_ff;
      nxt_genCtrl_ff = genCtrl_ff;
      nxt_palPage_ff = palPage_ff;
      nxt_rdData_ff  = 8'h00;
      if (regWr) begin
         case (regAddr)
            REG_MUX_SEL: begin
               nxt_muxSel_ff = regWrData;
               // selecting pass-through doubles as a software reset
               if (regWrData[5:0] == CODE_LEGACY) begin
                  nxt_genCtrl_ff = GEN_CTRL_RST;
                  nxt_palPage_ff = PAL_PAGE_RST;
               end
            end
            REG_GEN_CTRL: nxt_genCtrl_ff = regWrData;
            REG_PAL_PAGE: nxt_palPage_ff = regWrData;
            default: ;
         endcase
      end
      if (regRd) begin
         case (regAddr)
            REG_MUX_SEL:  nxt_rdData_ff = muxSel_ff;
            REG_GEN_CTRL: nxt_rdData_ff = genCtrl_ff;
            REG_PAL_PAGE: nxt_rdData_ff = palPage_ff;
            REG_STATUS: begin
               nxt_rdData_ff[STAT_UNDEF_BIT] = (mode_ff == M_UNDEF);
               nxt_rdData_ff[5:0]            = groupsLeft_ff;
            end
            default:      nxt_rdData_ff = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         muxSel_ff  <= MUX_SEL_RST;
         genCtrl_ff <= GEN_CTRL_RST;
         palPage_ff <= PAL_PAGE_RST;
         rdData_ff  <= 8'h00;
      end else begin
         muxSel_ff  <= nxt_muxSel_ff;
         genCtrl_ff <= nxt_genCtrl_ff;
         palPage_ff <= nxt_palPage_ff;
         rdData_ff  <= nxt_rdData_ff;
      end
   end

   assign regRdData = rdData_ff;

   // mode decode; bits 7:6 never reach it
   function automatic mode_t decodeMode(input logic [5:0] code, input logic nibEn);
      mode_t m;
      m = M_UNDEF;
      if (nibEn || code == CODE_NIBBLE) begin
         m = M_NIBBLE;
      end else if (code == CODE_LEGACY) begin
         m = M_LEGACY;
      end else begin
         case (code[5:2])
            CODE_PLANE1: m = M_PLANE1;
            CODE_PLANE2: m = M_PLANE2;
            CODE_PLANE4: m = M_PLANE4;
            CODE_PLANE8: m = M_PLANE8;
            default: begin
               case (code)
                  CODE_TC555, CODE_TC555_DBL: m = M_TC555;
                  CODE_TC565, CODE_TC565_DBL: m = M_TC565;
                  CODE_TC24_OVHI:             m = M_TC24_OVHI;
                  CODE_TC24_OVLO:             m = M_TC24_OVLO;
                  default:                    m = M_UNDEF;
               endcase
            end
         endcase
      end
      return m;
   endfunction : decodeMode

   // serialiser and per-dot output
   logic        nibbleEn;
   logic        bigEndian;
   logic [31:0] busOrdered;
   logic [15:0] nibbleWord;
   logic [31:0] grp;
   logic [4:0]  shamt;
   logic [5:0]  loadCount;
   logic [2:0]  loadLogW;
   logic [31:0] loadWord;
   logic [7:0]  ov;

   logic [31:0] word_ff;
   logic [4:0]  idx_ff;
   logic [2:0]  logW_ff;
   logic        pixValid_ff;
   logic [7:0]  paletteAddr_ff;
   logic        directColour_ff;
   logic [7:0]  red_ff;
   logic [7:0]  green_ff;
   logic [7:0]  blue_ff;
   logic [7:0]  overlay_ff;

   mode_t       nxt_mode_ff;
   logic [31:0] nxt_word_ff;
   logic [4:0]  nxt_idx_ff;
   logic [2:0]  nxt_logW_ff;
   logic [5:0]  nxt_groupsLeft_ff;
   logic        nxt_pixValid_ff;
   logic [7:0]  nxt_paletteAddr_ff;
   logic        nxt_directColour_ff;
   logic [7:0]  nxt_red_ff;
   logic [7:0]  nxt_green_ff;
   logic [7:0]  nxt_blue_ff;
   logic [7:0]  nxt_overlay_ff;

   assign nibbleEn  = genCtrl_ff[GCR_NIBBLE_MODE_BIT] & ~genCtrl_ff[GCR_SPLIT_XFER_BIT];
   assign bigEndian = genCtrl_ff[GCR_BIG_ENDIAN_BIT];

   always_comb begin
      for (int i = 0; i < 32; i++) begin
         busOrdered[i] = bigEndian ? pixSync[31-i] : pixSync[i];
      end
      nibbleWord = flagSync ? {busOrdered[31:28], busOrdered[23:20],
                               busOrdered[15:12], busOrdered[7:4]}
                            : {busOrdered[27:24], busOrdered[19:16],
                               busOrdered[11:8], busOrdered[3:0]};
      loadWord  = busOrdered;
      loadCount = 6'd1;
      loadLogW  = LOGW_32;
      // count per load follows the bus-width field of the code in the plane and 16-bit modes
      case (mode_ff)
         M_LEGACY: begin
            loadWord = {24'h00_0000, legacySync};
         end
         M_PLANE1: begin
            loadCount = 6'(6'd4 << muxSel_ff[1:0]);
            loadLogW  = LOGW_1;
         end
         M_PLANE2: begin
            loadCount = 6'(6'd2 << muxSel_ff[1:0]);
            loadLogW  = LOGW_2;
         end
         M_PLANE4: begin
            loadCount = 6'(6'd1 << muxSel_ff[1:0]);
            loadLogW  = LOGW_4;
         end
         M_PLANE8: begin
            loadCount = 6'(6'd1 << muxSel_ff[1:0]);
            loadLogW  = LOGW_8;
         end
         M_NIBBLE: begin
            loadWord  = {16'h0000, nibbleWord};
            loadCount = 6'd4;
            loadLogW  = LOGW_4;
         end
         M_TC555, M_TC565: begin
            loadCount = muxSel_ff[1] ? 6'd2 : 6'd1;
            loadLogW  = LOGW_16;
         end
         default: ;
      endcase
      shamt = 5'(idx_ff << logW_ff);
      grp   = word_ff >> shamt;
   end

   always_comb begin
      nxt_mode_ff         = decodeMode(muxSel_ff[5:0], nibbleEn);
      nxt_word_ff         = word_ff;
      nxt_idx_ff          = idx_ff;
      nxt_logW_ff         = logW_ff;
      nxt_groupsLeft_ff   = groupsLeft_ff;
      nxt_pixValid_ff     = 1'b0;
      nxt_paletteAddr_ff  = paletteAddr_ff;
      nxt_directColour_ff = directColour_ff;
      nxt_red_ff          = red_ff;
      nxt_green_ff        = green_ff;
      nxt_blue_ff         = blue_ff;
      nxt_overlay_ff      = overlay_ff;
      ov                  = 8'h00;
      if (mode_ff == M_UNDEF) begin
         nxt_groupsLeft_ff   = 6'd0;
         nxt_paletteAddr_ff  = 8'h00;
         nxt_directColour_ff = 1'b0;
         nxt_red_ff          = 8'h00;
         nxt_green_ff        = 8'h00;
         nxt_blue_ff         = 8'h00;
         nxt_overlay_ff      = 8'h00;
      end else if (flush) begin
         nxt_groupsLeft_ff = 6'd0;
      end else if (shiftRise) begin
         nxt_word_ff       = loadWord;
         nxt_idx_ff        = 5'd0;
         nxt_logW_ff       = loadLogW;
         nxt_groupsLeft_ff = loadCount;
      end else if (dotRise && groupsLeft_ff != 6'd0) begin
         nxt_idx_ff          = idx_ff + 5'd1;
         nxt_groupsLeft_ff   = groupsLeft_ff - 6'd1;
         nxt_pixValid_ff     = 1'b1;
         nxt_directColour_ff = 1'b0;
         nxt_red_ff          = 8'h00;
         nxt_green_ff        = 8'h00;
         nxt_blue_ff         = 8'h00;
         case (mode_ff)
            M_PLANE1: nxt_paletteAddr_ff = {palPage_ff[7:1], grp[0]};
            M_PLANE2: nxt_paletteAddr_ff = {palPage_ff[7:2], grp[1:0]};
            M_PLANE4, M_NIBBLE: nxt_paletteAddr_ff = {palPage_ff[7:4], grp[3:0]};
            M_TC555: begin
               ov           = {palPage_ff[7:1], grp[15]};
               nxt_red_ff   = {grp[14:10], 3'b000};
               nxt_green_ff = {grp[9:5], 3'b000};
               nxt_blue_ff  = {grp[4:0], 3'b000};
            end
            M_TC565: begin
               nxt_red_ff   = {grp[15:11], 3'b000};
               nxt_green_ff = {grp[10:5], 2'b00};
               nxt_blue_ff  = {grp[4:0], 3'b000};
            end
            M_TC24_OVHI: begin
               ov           = grp[31:24];
               nxt_red_ff   = grp[23:16];
               nxt_green_ff = grp[15:8];
               nxt_blue_ff  = grp[7:0];
            end
            M_TC24_OVLO: begin
               nxt_blue_ff  = grp[31:24];
               nxt_green_ff = grp[23:16];
               nxt_red_ff   = grp[15:8];
               ov           = grp[7:0];
            end
            default: nxt_paletteAddr_ff = grp[7:0];
         endcase
         if (mode_ff inside {M_TC555, M_TC565, M_TC24_OVHI, M_TC24_OVLO}) begin
            nxt_overlay_ff = ov;
            if (ov != 8'h00) begin
               nxt_paletteAddr_ff  = ov;
            end else begin
               nxt_directColour_ff = 1'b1;
            end
         end else begin
            nxt_overlay_ff = 8'h00;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mode_ff         <= M_LEGACY;
         word_ff         <= 32'h0000_0000;
         idx_ff          <= 5'd0;
         logW_ff         <= LOGW_32;
         groupsLeft_ff   <= 6'd0;
         pixValid_ff     <= 1'b0;
         paletteAddr_ff  <= 8'h00;
         directColour_ff <= 1'b0;
         red_ff          <= 8'h00;
         green_ff        <= 8'h00;
         blue_ff         <= 8'h00;
         overlay_ff      <= 8'h00;
      end else begin
         mode_ff         <= nxt_mode_ff;
         word_ff         <= nxt_word_ff;
         idx_ff          <= nxt_idx_ff;
         logW_ff         <= nxt_logW_ff;
         groupsLeft_ff   <= nxt_groupsLeft_ff;
         pixValid_ff     <= nxt_pixValid_ff;
         paletteAddr_ff  <= nxt_paletteAddr_ff;
         directColour_ff <= nxt_directColour_ff;
         red_ff          <= nxt_red_ff;
         green_ff        <= nxt_green_ff;
         blue_ff         <= nxt_blue_ff;
         overlay_ff      <= nxt_overlay_ff;
      end
   end

   assign pixValid     = pixValid_ff;
   assign paletteAddr  = paletteAddr_ff;
   assign directColour = directColour_ff;
   assign red          = red_ff;
   assign green        = green_ff;
   assign blue         = blue_ff;
   assign overlay      = overlay_ff;

   // checks
   logic pixTop;
   assign pixTop = pixSync[31];

   property p_sel_top_ignored;
      @(posedge sys_clk) disable iff (rst)
      regWr && regAddr == REG_MUX_SEL && regWrData[5:0] == CODE_LEGACY
      |=> ##1 mode_ff == M_LEGACY;
   endproperty
   a_sel_top_ignored: assert property (p_sel_top_ignored)
      else $error("pass-through code not decoded with top bits set");

   property p_load_count;
      @(posedge sys_clk) disable iff (rst)
      shiftRise && !flush && mode_ff == M_PLANE1
      |=> idx_ff == 5'd0 && groupsLeft_ff == 6'(6'd4 << $past(muxSel_ff[1:0]));
   endproperty
   a_load_count: assert property (p_load_count)
      else $error("single-plane load count wrong");

   property p_dot_step;
      @(posedge sys_clk) disable iff (rst)
      dotRise && !shiftRise && !flush && mode_ff != M_UNDEF && groupsLeft_ff != 6'd0
      |=> pixValid_ff && idx_ff == $past(idx_ff) + 5'd1;
   endproperty
   a_dot_step: assert property (p_dot_step)
      else $error("dot edge did not emit next group");

   property p_no_dot_when_empty;
      @(posedge sys_clk) disable iff (rst)
      groupsLeft_ff == 6'd0 && !shiftRise |=> !pixValid_ff;
   endproperty
   a_no_dot_when_empty: assert property (p_no_dot_when_empty)
      else $error("pixel emitted with nothing loaded");

   property p_left_justify;
      @(posedge sys_clk) disable iff (rst)
      pixValid_ff && directColour_ff && (mode_ff == M_TC555 || mode_ff == M_TC565)
      |-> red_ff[2:0] == 3'b000 && blue_ff[2:0] == 3'b000;
   endproperty
   a_left_justify: assert property (p_left_justify)
      else $error("16-bit colour field not left-justified");

   property p_overlay_wins;
      @(posedge sys_clk) disable iff (rst)
      pixValid_ff && overlay_ff != 8'h00 |-> !directColour_ff && paletteAddr_ff == overlay_ff;
   endproperty
   a_overlay_wins: assert property (p_overlay_wins)
      else $error("non-zero overlay did not select palette");

   property p_overlay_page;
      @(posedge sys_clk) disable iff (rst)
      pixValid_ff && mode_ff == M_TC555 && $stable(palPage_ff)
      |-> overlay_ff[7:1] == palPage_ff[7:1];
   endproperty
   a_overlay_page: assert property (p_overlay_page)
      else $error("5-5-5 overlay upper bits not from page register");

   property p_big_endian;
      @(posedge sys_clk) disable iff (rst)
      shiftRise && !flush && bigEndian && mode_ff == M_PLANE8
      |=> word_ff[0] == $past(pixTop);
   endproperty
   a_big_endian: assert property (p_big_endian)
      else $error("big-endian bus not reversed on load");

   property p_undef_silent;
      @(posedge sys_clk) disable iff (rst)
      mode_ff == M_UNDEF ##1 mode_ff == M_UNDEF |-> !pixValid_ff && paletteAddr_ff == 8'h00;
   endproperty
   a_undef_silent: assert property (p_undef_silent)
      else $error("undefined mode produced output");

endmodule : pixel_bus_mode_unpacker

/* src/pixel_unpack_pkg.sv */
package pixel_unpack_pkg;

   // register indexes on the control port
   localparam logic [3:0] REG_MUX_SEL  = 4'h0;
   localparam logic [3:0] REG_GEN_CTRL = 4'h1;
   localparam logic [3:0] REG_PAL_PAGE = 4'h2;
   localparam logic [3:0] REG_STATUS   = 4'h3;

   // reset values
   localparam logic [7:0] MUX_SEL_RST  = 8'h2D;
   localparam logic [7:0] GEN_CTRL_RST = 8'h03;
   localparam logic [7:0] PAL_PAGE_RST = 8'h00;

   // general control field positions
   localparam int GCR_BIG_ENDIAN_BIT  = 6;
   localparam int GCR_NIBBLE_MODE_BIT = 3;
   localparam int GCR_SPLIT_XFER_BIT  = 2;

   // status field positions
   localparam int STAT_UNDEF_BIT = 7;

   // mode codes on the low six select bits
   localparam logic [5:0] CODE_LEGACY    = 6'h2D;
   localparam logic [5:0] CODE_NIBBLE    = 6'h1F;
   localparam logic [3:0] CODE_PLANE1    = 4'h4;
   localparam logic [3:0] CODE_PLANE2    = 4'h5;
   localparam logic [3:0] CODE_PLANE4    = 4'h6;
   localparam logic [3:0] CODE_PLANE8    = 4'h7;
   localparam logic [5:0] CODE_TC555     = 6'h08;
   localparam logic [5:0] CODE_TC565     = 6'h09;
   localparam logic [5:0] CODE_TC555_DBL = 6'h0A;
   localparam logic [5:0] CODE_TC565_DBL = 6'h0B;
   localparam logic [5:0] CODE_TC24_OVHI = 6'h0E;
   localparam logic [5:0] CODE_TC24_OVLO = 6'h0D;

   // log2 of the group width per mode
   localparam logic [2:0] LOGW_1  = 3'h0;
   localparam logic [2:0] LOGW_2  = 3'h1;
   localparam logic [2:0] LOGW_4  = 3'h2;
   localparam logic [2:0] LOGW_8  = 3'h3;
   localparam logic [2:0] LOGW_16 = 3'h4;
   localparam logic [2:0] LOGW_32 = 3'h5;

   typedef enum logic [3:0] {
      M_LEGACY,
      M_PLANE1,
      M_PLANE2,
      M_PLANE4,
      M_PLANE8,
      M_NIBBLE,
      M_TC555,
      M_TC565,
      M_TC24_OVHI,
      M_TC24_OVLO,
      M_UNDEF
   } mode_t;

endpackage : pixel_unpack_pkg

/* src/sync_2ff.sv */
`timescale 1ns/1ps
module sync_2ff #(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // asynchronous levels in, synchronised levels out
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] stable_ff;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         meta_ff   <= '0;
         stable_ff <= '0;
      end else begin
         meta_ff   <= asyncIn;
         stable_ff <= meta_ff;
      end
   end

   assign syncOut = stable_ff;
endmodule : sync_2ff

/* testbench/pixel_serial_model.sv */
`timescale 1ns/1ps
module pixel_serial_model (
   // clock
   input  wire logic        sys_clk,
   // pins toward the unpacker
   output logic             shiftClock,
   output logic             perDotClock,
   output logic             nibbleHalfFlag,
   output logic      [31:0] pixelBus,
   output logic      [7:0]  legacyPort
);
   initial begin
      shiftClock = 1'b0;
      perDotClock = 1'b0;
      nibbleHalfFlag = 1'b0;
      pixelBus = 32'h0000_0000;
      legacyPort = 8'h00;
   end

   // one bus load; hp sets how many cycles each clock level lasts
   task automatic send(input logic [31:0] w, input logic f, input int dots, input int hp);
      pixelBus <= w;
      legacyPort <= w[31:24];
      nibbleHalfFlag <= f;
      repeat (hp) @(posedge sys_clk);
      shiftClock <= 1'b1;
      repeat (hp) @(posedge sys_clk);
      shiftClock <= 1'b0;
      // hold time over, so the old load is no longer shown
      pixelBus <= ~w;
      legacyPort <= ~w[31:24];
      // dot count comes from software, not from the mode
      for (int i = 0; i < dots; i++) begin
         repeat (hp) @(posedge sys_clk);
         perDotClock <= 1'b1;
         repeat (hp) @(posedge sys_clk);
         perDotClock <= 1'b0;
      end
      repeat (hp + 6) @(posedge sys_clk);
   endtask : send
endmodule : pixel_serial_model

/* testbench/testbench.sv */
`timescale 1ns/1ps
module testbench
   import pixel_unpack_pkg::*;
();
   localparam int          LIMIT = 40000;
   localparam logic [31:0] W0    = 32'h8A5C_3E71;
   localparam logic [31:0] W1    = 32'h00A5_5A00;
   logic        sys_clk;
   logic        rst;
   logic [3:0]  regAddr;
   logic [7:0]  regWrData;
   logic        regWr;
   logic        regRd;
   logic [7:0]  regRdData;
   logic        shiftClock;
   logic        perDotClock;
   logic        nibbleHalfFlag;
   logic [31:0] pixelBus;
   logic [7:0]  legacyPort;
   logic        pixValid;
   logic [7:0]  paletteAddr;
   logic        directColour;
   logic [7:0]  red;
   logic [7:0]  green;
   logic [7:0]  blue;
   logic [7:0]  overlay;
   logic [40:0] dotQ[$];
   int          fails;
   int          checkCount;
   int          cycles;

   pixel_bus_mode_unpacker i_pixel_bus_mode_unpacker (
      .sys_clk, .rst, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
      .shiftClock, .perDotClock, .nibbleHalfFlag, .pixelBus, .legacyPort,
      .pixValid, .paletteAddr, .directColour, .red, .green, .blue, .overlay
   );
   pixel_serial_model i_pixel_serial_model (
      .sys_clk, .shiftClock, .perDotClock, .nibbleHalfFlag, .pixelBus, .legacyPort
   );

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   // every emitted dot is queued for the running scenario
   always @(posedge sys_clk) begin
      if (pixValid === 1'b1) dotQ.push_back({paletteAddr, directColour, red, green, blue, overlay});
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fails++;
         results();
      end
   end

   task automatic check(input logic [63:0] got, input logic [63:0] exp);
      checkCount++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : check

   task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask : regWrite

   task automatic regRead(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask : regRead

   function automatic logic [32:0] tcExp(input logic [5:0] c, input logic [31:0] d,
                                         input int i, input logic [7:0] pg);
      logic [15:0] h;
      logic [7:0]  r;
      logic [7:0]  g;
      logic [7:0]  b;
      logic [7:0]  ov;
      h = d[16 * i +: 16];
      ov = 8'h00;
      r = {h[15:11], 3'b000};
      g = {h[10:5], 2'b00};
      b = {h[4:0], 3'b000};
      if (c == CODE_TC555 || c == CODE_TC555_DBL) begin
         ov = {pg[7:1], h[15]};
         r = {h[14:10], 3'b000};
         g = {h[9:5], 3'b000};
      end else if (c == CODE_TC24_OVHI) begin
         {ov, r, g, b} = d;
      end else if (c == CODE_TC24_OVLO) begin
         {b, g, r, ov} = d;
      end
      return {ov == 8'h00, r, g, b, ov};
   endfunction : tcExp

   task automatic testReset();
      logic [7:0] d;
      regRead(REG_MUX_SEL, d);
      check(d, MUX_SEL_RST);
      regRead(REG_GEN_CTRL, d);
      check(d, GEN_CTRL_RST);
      regRead(4'h9, d);
      check(d, 8'h00);
      dotQ.delete();
      i_pixel_serial_model.send(32'h5A00_00C3, 1'b0, 1, 3);
      check(dotQ.size(), 1);
      check(dotQ[0][40:32], {8'h5A, 1'b0});
      $display("test reset_legacy done");
   endtask : testReset

   task automatic testPlanes();
      int          w;
      int          n;
      logic [7:0]  m;
      logic [31:0] rv;
      regWrite(REG_PAL_PAGE, 8'hB6);
      for (int c = 16; c < 31; c++) begin
         w = 1 << c[3:2];
         n = ((c[3:2] == 2'd3) ? 8 : 4) << c[1:0];
         n = n / w;
         m = 8'((1 << w) - 1);
         regWrite(REG_MUX_SEL, {2'b11, 6'(c)});
         dotQ.delete();
         i_pixel_serial_model.send(W0, 1'b0, n + 1, 3 + 2 * c[0]);
         check(dotQ.size(), n);
         for (int k = 0; k < n; k++) begin
            check(dotQ[k][40:33], (8'hB6 & ~m) | (8'(W0 >> (k * w)) & m));
         end
      end
      // plane 8 with reversed bit order: bus bit 31 becomes bit 0 of the first dot
      regWrite(REG_GEN_CTRL, 8'h40);
      regWrite(REG_MUX_SEL, 8'h1E);
      rv = {<<{W0}};
      dotQ.delete();
      i_pixel_serial_model.send(W0, 1'b0, 4, 3);
      check(dotQ.size(), 4);
      for (int k = 0; k < 4; k++) begin
         check(dotQ[k][40:33], rv[8 * k +: 8]);
      end
      regWrite(REG_GEN_CTRL, 8'h00);
      $display("test planes done");
   endtask : testPlanes

   task automatic testNibble();
      for (int s = 0; s < 2; s++) begin
         regWrite(REG_MUX_SEL, s ? 8'h1E : {2'b00, CODE_NIBBLE});
         regWrite(REG_GEN_CTRL, s ? 8'h08 : 8'h00);
         for (int f = 0; f < 2; f++) begin
            dotQ.delete();
            i_pixel_serial_model.send(W0, f[0], 4, 4);
            check(dotQ.size(), 4);
            for (int k = 0; k < 4; k++) begin
               check(dotQ[k][40:33], {4'hB, W0[8 * k + 4 * f +: 4]});
            end
         end
      end
      regWrite(REG_GEN_CTRL, 8'h00);
      $display("test nibble done");
   endtask : testNibble

   task automatic testTrue();
      logic [5:0]  codes[6];
      logic [31:0] d;
      logic [32:0] e;
      int          n;
      codes = '{CODE_TC555, CODE_TC565, CODE_TC555_DBL, CODE_TC565_DBL,
                CODE_TC24_OVHI, CODE_TC24_OVLO};
      for (int be = 0; be < 2; be++) begin
         regWrite(REG_GEN_CTRL, be ? 8'h40 : 8'h00);
         regWrite(REG_PAL_PAGE, be ? 8'h06 : 8'h00);
         foreach (codes[c]) begin
            regWrite(REG_MUX_SEL, {2'b00, codes[c]});
            n = (codes[c] == CODE_TC555_DBL || codes[c] == CODE_TC565_DBL) ? 2 : 1;
            for (int j = 0; j < 2; j++) begin
               // second load keeps the 24-bit overlay byte low
               d = j ? W1 : W0;
               dotQ.delete();
               i_pixel_serial_model.send(d, 1'b0, n, 3);
               if (be) d = {<<{d}};
               check(dotQ.size(), n);
               for (int i = 0; i < n; i++) begin
                  e = tcExp(codes[c], d, i, be ? 8'h06 : 8'h00);
                  check(dotQ[i][32:0], e);
                  if (e[32] == 1'b0) check(dotQ[i][40:33], e[7:0]);
               end
            end
         end
      end
      $display("test truecolour done");
   endtask : testTrue

   task automatic testUndef();
      logic [7:0] d;
      regWrite(REG_MUX_SEL, 8'h3F);
      dotQ.delete();
      i_pixel_serial_model.send(W0, 1'b0, 2, 3);
      check(dotQ.size(), 0);
      regRead(REG_STATUS, d);
      check(d[7], 1'b1);
      regWrite(REG_GEN_CTRL, 8'h40);
      regWrite(REG_PAL_PAGE, 8'h77);
      regWrite(REG_MUX_SEL, 8'hED);
      regRead(REG_GEN_CTRL, d);
      check(d, GEN_CTRL_RST);
      regRead(REG_PAL_PAGE, d);
      check(d, PAL_PAGE_RST);
      regRead(REG_STATUS, d);
      check(d[7], 1'b0);
      $display("test undef_softreset done");
   endtask : testUndef

   task automatic results();
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : results

   initial begin
      rst = 1'b1;
      regAddr = 4'h0;
      regWrData = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      fails = 0;
      checkCount = 0;
      repeat (12) @(posedge sys_clk);
      rst <= 1'b0;
      testReset();
      testPlanes();
      testNibble();
      testTrue();
      testUndef();
      results();
   end
endmodule : testbench
